// >>> inc/arb_pkg.sv
/*
 * Shared constants for the external bus arbitration block.
 * Assumes a single 40 MHz system clock and a 32-bit Avalon-MM register port.
 */
package arb_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int NUM_LINES = 6;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 4;

    // Register byte offsets.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;

    // Control register fields.
    localparam int CTRL_BUS_WANT = 0;
    localparam int CTRL_BG_DMA = 1;
    localparam int CTRL_DMA_ONE_EN = 2;
    localparam int CTRL_DMA_TWO_EN = 3;
    localparam int CTRL_PRIO_REQ = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Status register fields.
    localparam int ST_MASTER = 0;
    localparam int ST_HOST_OWNS = 1;
    localparam int ST_DMA_SUSP = 2;
    localparam int ST_NUM_LO = 3;
    localparam int ST_REQ_LO = 6;
    localparam int ST_GNT_ONE = 12;
    localparam int ST_GNT_TWO = 13;
    localparam int ST_MIDX_LO = 14;
    localparam int ST_MVALID = 17;

    // Processor number codes that leave the device without a request line.
    localparam logic [2:0] NUM_SINGLE = 3'h0;
    localparam logic [2:0] NUM_INVALID = 3'h7;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_RELEASE,
        HOST_GRANTED
    } host_state_e;
endpackage

// >>> inc/arb_sel_if.sv
/*
 * Carrier between the arbiter core and its priority selector.
 * Assumes both ends share the system clock; the path is combinational.
 */
`timescale 1ns/100ps
interface arb_sel_if #(
    parameter int N = 6
);
    logic [N-1:0] req;
    logic rotate;
    logic [2:0] last_idx;
    logic last_valid;
    logic [2:0] win_idx;
    logic win_valid;

    modport arbiter (
        output req,
        output rotate,
        output last_idx,
        output last_valid,
        input win_idx,
        input win_valid
    );
    modport selector (
        input req,
        input rotate,
        input last_idx,
        input last_valid,
        output win_idx,
        output win_valid
    );
endinterface

// >>> logic/bus_arbiter.sv
/*
 * External bus ownership and arbitration for one processor on a shared bus.
 * Assumes all pins are synchronous to clk_sys_i; open-drain and three-state
 * pins are resolved outside from the value and enable pairs.
 */
`timescale 1ns/100ps
module bus_arbiter #(
    parameter int N = arb_pkg::NUM_LINES
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Avalon-MM register slave.
    input wire logic [arb_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Host handshake.
    input wire logic host_bus_request_n_i,
    input wire logic host_select_n_i,
    input wire logic host_bus_grant_n_i,
    output logic host_bus_grant_n_o,
    output logic host_bus_grant_oe_o,
    output logic host_wait_ready_o,
    output logic host_wait_ready_oe_o,
    // External DMA handshake.
    input wire logic ext_dma_request_one_n_i,
    input wire logic ext_dma_request_two_n_i,
    output logic ext_dma_grant_one_n_o,
    output logic ext_dma_grant_two_n_o,
    output logic ext_dma_grant_oe_o,
    // Multiprocessor arbitration.
    input wire logic [2:0] processor_number_pins_i,
    input wire logic [N-1:0] peer_bus_request_lines_n_i,
    output logic [N-1:0] peer_bus_request_lines_n_o,
    output logic [N-1:0] peer_bus_request_lines_oe_o,
    input wire logic rotating_priority_select_i,
    input wire logic priority_access_n_i,
    output logic priority_access_n_o,
    output logic priority_access_oe_o,
    // Bus drivers and clock output.
    output logic ext_bus_oe_o,
    output logic bus_master_clock_out_o,
    output logic bus_master_clock_oe_o
);
    arb_sel_if #(.N(N)) sel ();

    priority_select #(.N(N)) u_sel (
        .sel(sel)
    );

    // Configuration and register state.
    logic [2:0] num_ff;
    logic [arb_pkg::CTRL_W-1:0] ctrl_ff;
    logic [arb_pkg::CTRL_W-1:0] nxt_ctrl;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wait_ff;
    logic nxt_wait;

    // Arbitration state.
    logic [2:0] midx_ff;
    logic [2:0] nxt_midx;
    logic mvalid_ff;
    logic nxt_mvalid;
    logic master_ff;
    logic nxt_master;
    logic own_req_ff;
    logic nxt_own_req;
    logic [N-1:0] req_oe_ff;
    logic [N-1:0] nxt_req_oe;
    logic prio_oe_ff;
    logic nxt_prio_oe;

    // Host state.
    arb_pkg::host_state_e host_ff;
    arb_pkg::host_state_e nxt_host;
    logic hgrant_n_ff;
    logic nxt_hgrant_n;
    logic hgrant_oe_ff;
    logic nxt_hgrant_oe;
    logic wait_oe_ff;
    logic nxt_wait_oe;
    logic bus_oe_ff;
    logic nxt_bus_oe;
    logic clk_ff;
    logic nxt_clk;
    logic clk_oe_ff;
    logic nxt_clk_oe;

    // DMA state.
    logic gnt1_n_ff;
    logic nxt_gnt1_n;
    logic gnt2_n_ff;
    logic nxt_gnt2_n;
    logic done1_ff;
    logic nxt_done1;
    logic done2_ff;
    logic nxt_done2;
    logic dma_oe_ff;
    logic nxt_dma_oe;

    // Shared decode.
    logic single;
    logic [2:0] own_idx;
    logic host_req;
    logic host_owns;
    logic prio_seen;
    logic [N-1:0] req_vec;
    logic dma_ok;
    logic acc;

    always_comb begin
        single = (num_ff == arb_pkg::NUM_SINGLE) || (num_ff == arb_pkg::NUM_INVALID);
        own_idx = single ? 3'h0 : 3'(num_ff - 3'h1);
        host_req = !host_bus_request_n_i;
        host_owns = master_ff ? (host_ff == arb_pkg::HOST_GRANTED) : !host_bus_grant_n_i;
        prio_seen = !priority_access_n_i && !prio_oe_ff;
        req_vec = ~peer_bus_request_lines_n_i;
        if (!single) begin
            req_vec[own_idx] = own_req_ff;
        end
        dma_ok = master_ff && (host_ff == arb_pkg::HOST_IDLE) && !host_req && !prio_seen;
        acc = (avs_read_i || avs_write_i) && wait_ff;
    end

    assign sel.req = req_vec;
    assign sel.rotate = rotating_priority_select_i;
    assign sel.last_idx = midx_ff;
    assign sel.last_valid = mvalid_ff;

    // Register slave: one wait cycle, then the access completes.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_rdata = rdata_ff;
        nxt_wait = !acc;
        if (acc && avs_read_i) begin
            nxt_rdata = 32'h0;
            case (avs_address_i)
                arb_pkg::OFS_CTRL: begin
                    nxt_rdata[arb_pkg::CTRL_W-1:0] = ctrl_ff;
                end
                arb_pkg::OFS_STATUS: begin
                    nxt_rdata[arb_pkg::ST_MASTER] = master_ff;
                    nxt_rdata[arb_pkg::ST_HOST_OWNS] = host_owns;
                    nxt_rdata[arb_pkg::ST_DMA_SUSP] = master_ff && prio_seen && ctrl_ff[arb_pkg::CTRL_BG_DMA];
                    nxt_rdata[arb_pkg::ST_NUM_LO +: 3] = num_ff;
                    nxt_rdata[arb_pkg::ST_REQ_LO +: N] = req_vec;
                    nxt_rdata[arb_pkg::ST_GNT_ONE] = !gnt1_n_ff;
                    nxt_rdata[arb_pkg::ST_GNT_TWO] = !gnt2_n_ff;
                    nxt_rdata[arb_pkg::ST_MIDX_LO +: 3] = midx_ff;
                    nxt_rdata[arb_pkg::ST_MVALID] = mvalid_ff;
                end
                default: begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
        if (avs_write_i && !wait_ff && avs_byteenable_i[0] && avs_address_i == arb_pkg::OFS_CTRL) begin
            nxt_ctrl = avs_writedata_i[arb_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            num_ff <= processor_number_pins_i;
            ctrl_ff <= arb_pkg::CTRL_RESET;
            rdata_ff <= 32'h0;
            wait_ff <= 1'b1;
        end else begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            wait_ff <= nxt_wait;
        end
    end

    // Arbitration: a host request or host ownership freezes the master choice.
    always_comb begin
        nxt_midx = midx_ff;
        nxt_mvalid = mvalid_ff;
        if (!(host_req || host_owns)) begin
            if (!(mvalid_ff && req_vec[midx_ff]) && sel.win_valid) begin
                nxt_midx = sel.win_idx;
                nxt_mvalid = 1'b1;
            end
        end
        nxt_master = single || (nxt_mvalid && nxt_midx == own_idx);
        nxt_own_req = ctrl_ff[arb_pkg::CTRL_BUS_WANT] ||
            (ctrl_ff[arb_pkg::CTRL_BG_DMA] && !(master_ff && prio_seen));
        nxt_req_oe = '0;
        if (!single && nxt_own_req) begin
            nxt_req_oe[own_idx] = 1'b1;
        end
        nxt_prio_oe = !nxt_master && ctrl_ff[arb_pkg::CTRL_PRIO_REQ] && ctrl_ff[arb_pkg::CTRL_BUS_WANT];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            midx_ff <= 3'h0;
            mvalid_ff <= 1'b0;
            master_ff <= 1'b0;
            own_req_ff <= 1'b0;
            req_oe_ff <= '0;
            prio_oe_ff <= 1'b0;
        end else begin
            midx_ff <= nxt_midx;
            mvalid_ff <= nxt_mvalid;
            master_ff <= nxt_master;
            own_req_ff <= nxt_own_req;
            req_oe_ff <= nxt_req_oe;
            prio_oe_ff <= nxt_prio_oe;
        end
    end

    // Host handshake: release the bus one cycle before the grant goes low.
    always_comb begin
        nxt_host = host_ff;
        case (host_ff)
            arb_pkg::HOST_IDLE: begin
                if (host_req && master_ff) begin
                    nxt_host = arb_pkg::HOST_RELEASE;
                end
            end
            arb_pkg::HOST_RELEASE: begin
                nxt_host = host_req ? arb_pkg::HOST_GRANTED : arb_pkg::HOST_IDLE;
            end
            arb_pkg::HOST_GRANTED: begin
                if (!host_req) begin
                    nxt_host = arb_pkg::HOST_IDLE;
                end
            end
            default: begin
                nxt_host = arb_pkg::HOST_IDLE;
            end
        endcase
        nxt_hgrant_n = !(nxt_host == arb_pkg::HOST_GRANTED);
        nxt_hgrant_oe = nxt_master;
        nxt_wait_oe = !host_select_n_i && host_req;
        nxt_bus_oe = nxt_master && (nxt_host == arb_pkg::HOST_IDLE) && !host_req;
        nxt_clk = !clk_ff;
        nxt_clk_oe = nxt_master && (nxt_host != arb_pkg::HOST_GRANTED);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            host_ff <= arb_pkg::HOST_IDLE;
            hgrant_n_ff <= 1'b1;
            hgrant_oe_ff <= 1'b0;
            wait_oe_ff <= 1'b0;
            bus_oe_ff <= 1'b0;
            clk_ff <= 1'b0;
            clk_oe_ff <= 1'b0;
        end else begin
            host_ff <= nxt_host;
            hgrant_n_ff <= nxt_hgrant_n;
            hgrant_oe_ff <= nxt_hgrant_oe;
            wait_oe_ff <= nxt_wait_oe;
            bus_oe_ff <= nxt_bus_oe;
            clk_ff <= nxt_clk;
            clk_oe_ff <= nxt_clk_oe;
        end
    end

    // External DMA: one grant pulse per request, re-armed when the request drops.
    always_comb begin
        nxt_gnt1_n = 1'b1;
        nxt_gnt2_n = 1'b1;
        nxt_done1 = done1_ff && !ext_dma_request_one_n_i;
        nxt_done2 = done2_ff && !ext_dma_request_two_n_i;
        if (dma_ok && ctrl_ff[arb_pkg::CTRL_DMA_ONE_EN] && !ext_dma_request_one_n_i && !done1_ff) begin
            nxt_gnt1_n = 1'b0;
            nxt_done1 = 1'b1;
        end else if (dma_ok && ctrl_ff[arb_pkg::CTRL_DMA_TWO_EN] && !ext_dma_request_two_n_i && !done2_ff) begin
            nxt_gnt2_n = 1'b0;
            nxt_done2 = 1'b1;
        end
        nxt_dma_oe = nxt_master;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            gnt1_n_ff <= 1'b1;
            gnt2_n_ff <= 1'b1;
            done1_ff <= 1'b0;
            done2_ff <= 1'b0;
            dma_oe_ff <= 1'b0;
        end else begin
            gnt1_n_ff <= nxt_gnt1_n;
            gnt2_n_ff <= nxt_gnt2_n;
            done1_ff <= nxt_done1;
            done2_ff <= nxt_done2;
            dma_oe_ff <= nxt_dma_oe;
        end
    end

    // Open-drain style pins only ever pull low; the enable carries the level.
    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign host_bus_grant_n_o = hgrant_n_ff;
    assign host_bus_grant_oe_o = hgrant_oe_ff;
    assign host_wait_ready_o = 1'b0;
    assign host_wait_ready_oe_o = wait_oe_ff;
    assign ext_dma_grant_one_n_o = gnt1_n_ff;
    assign ext_dma_grant_two_n_o = gnt2_n_ff;
    assign ext_dma_grant_oe_o = dma_oe_ff;
    assign peer_bus_request_lines_n_o = '0;
    assign peer_bus_request_lines_oe_o = req_oe_ff;
    assign priority_access_n_o = 1'b0;
    assign priority_access_oe_o = prio_oe_ff;
    assign ext_bus_oe_o = bus_oe_ff;
    assign bus_master_clock_out_o = clk_ff;
    assign bus_master_clock_oe_o = clk_oe_ff;
endmodule

// >>> logic/priority_select.sv
/*
 * Priority selector: picks the winning bus request line.
 * Assumes the request vector is already sampled and stable for the cycle.
 */
`timescale 1ns/100ps
module priority_select #(
    parameter int N = 6
) (
    // Selection carrier.
    arb_sel_if.selector sel
);
    function automatic logic [2:0] first_from(input logic [N-1:0] r, input logic [2:0] start);
        logic [2:0] pos;
        logic [2:0] found;
        logic hit;
        found = 3'h0;
        hit = 1'b0;
        pos = start;
        for (int i = 0; i < N; i++) begin
            if (!hit && r[pos]) begin
                found = pos;
                hit = 1'b1;
            end
            pos = (pos == 3'(N - 1)) ? 3'h0 : 3'(pos + 3'h1);
        end
        return found;
    endfunction

    logic [2:0] start;

    always_comb begin
        start = 3'h0;
        if (sel.rotate && sel.last_valid) begin
            start = (sel.last_idx == 3'(N - 1)) ? 3'h0 : 3'(sel.last_idx + 3'h1);
        end
    end

    assign sel.win_idx = first_from(sel.req, start);
    assign sel.win_valid = |sel.req;
endmodule

// >>> test/bus_arbiter_checker.sv
/* Timing checks on the arbiter's ports.
   Assumes one clock domain and the plain ports of the top module. */
`timescale 1ns/100ps
module bus_arbiter_checker #(
    parameter int N = 6
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic host_bus_request_n_i,
    input wire logic host_select_n_i,
    input wire logic host_bus_grant_n_o,
    input wire logic host_bus_grant_oe_o,
    input wire logic host_wait_ready_oe_o,
    input wire logic ext_dma_request_one_n_i,
    input wire logic ext_dma_grant_one_n_o,
    input wire logic ext_dma_grant_two_n_o,
    input wire logic ext_dma_grant_oe_o,
    input wire logic [N-1:0] peer_bus_request_lines_oe_o,
    input wire logic priority_access_n_i,
    input wire logic priority_access_oe_o,
    input wire logic ext_bus_oe_o,
    input wire logic bus_master_clock_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    sequence host_take;
        host_bus_grant_oe_o && !host_bus_request_n_i && host_bus_grant_n_o ##1 !host_bus_request_n_i;
    endsequence
    sequence prio_foreign;
        (!priority_access_n_i && !priority_access_oe_o) [*2];
    endsequence
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest late");
    a_host_release: assert property (host_bus_grant_oe_o && !host_bus_request_n_i |=> !ext_bus_oe_o)
        else $error("bus not released");
    a_grant_delay: assert property (host_take |=> !host_bus_grant_n_o)
        else $error("grant late");
    a_grant_hold: assert property (!host_bus_grant_n_o && !host_bus_request_n_i |=> !host_bus_grant_n_o)
        else $error("grant dropped early");
    a_grant_drop: assert property (!host_bus_grant_n_o && host_bus_request_n_i |=> host_bus_grant_n_o)
        else $error("grant held too long");
    a_host_freeze: assert property (!host_bus_request_n_i [*3] |=> $stable(host_bus_grant_oe_o))
        else $error("master changed under host");
    a_ready_wait: assert property (1'b1 |=> host_wait_ready_oe_o ==
        (!$past(host_select_n_i) && !$past(host_bus_request_n_i)))
        else $error("ready wrong");
    a_own_line: assert property ($onehot0(peer_bus_request_lines_oe_o))
        else $error("several lines driven");
    a_dma_pulse: assert property (!ext_dma_grant_one_n_o |=> ext_dma_grant_one_n_o)
        else $error("grant one too long");
    a_dma_cause: assert property ($fell(ext_dma_grant_one_n_o) |->
        !$past(ext_dma_request_one_n_i) && ext_dma_grant_oe_o)
        else $error("grant one without cause");
    a_prio_suspend: assert property (prio_foreign |=> ext_dma_grant_one_n_o && ext_dma_grant_two_n_o)
        else $error("dma granted under priority access");
    a_clock_tri: assert property (bus_master_clock_oe_o |-> host_bus_grant_oe_o && host_bus_grant_n_o)
        else $error("clock driven wrongly");
    a_grant_owner: assert property (host_bus_grant_oe_o == ext_dma_grant_oe_o)
        else $error("grant drivers disagree");
    a_prio_slave: assert property (priority_access_oe_o |-> !host_bus_grant_oe_o)
        else $error("priority access driven by master");
endmodule
bind bus_arbiter bus_arbiter_checker #(.N(N)) u_bus_arbiter_checker (
    .clk_sys_i, .resetn_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .host_bus_request_n_i,
    .host_select_n_i, .host_bus_grant_n_o, .host_bus_grant_oe_o, .host_wait_ready_oe_o,
    .ext_dma_request_one_n_i, .ext_dma_grant_one_n_o, .ext_dma_grant_two_n_o, .ext_dma_grant_oe_o,
    .peer_bus_request_lines_oe_o, .priority_access_n_i, .priority_access_oe_o, .ext_bus_oe_o,
    .bus_master_clock_oe_o
);

// >>> test/peer_bus_model.sv
/* Far side of the arbiter: peer processors, the wired lines and their pull-ups.
   Assumes the bench says which peers request and whether a peer slave asks for priority. */
`timescale 1ns/100ps
module peer_bus_model (
    // Commands from the bench.
    input wire logic [5:0] peer_req_n_i,
    input wire logic prio_req_n_i,
    // Device drives.
    input wire logic [5:0] own_req_n_i,
    input wire logic [5:0] own_req_oe_i,
    input wire logic prio_n_i,
    input wire logic prio_oe_i,
    input wire logic grant_n_i,
    input wire logic grant_oe_i,
    input wire logic ready_i,
    input wire logic ready_oe_i,
    // Resolved wires.
    output logic [5:0] req_lines_n_o,
    output logic prio_line_n_o,
    output logic grant_line_n_o,
    output logic ready_line_o
);
    // Unused lines rest high through their pull-ups; every line, the own line too, is low when the bench or the device's drive pulls it.
    assign req_lines_n_o = peer_req_n_i & ~(own_req_oe_i & ~own_req_n_i);
    assign prio_line_n_o = prio_req_n_i & ~(prio_oe_i & ~prio_n_i);
    // A peer master keeps the grant inactive, as no host is granted by it here.
    assign grant_line_n_o = grant_oe_i ? grant_n_i : 1'b1;
    assign ready_line_o = ready_oe_i ? ready_i : 1'b1;
endmodule

// >>> test/test_bus_arbiter.sv
/* Self-checking bench for bus_arbiter.
   Assumes peer_bus_model resolves the wired lines; registers are reached over Avalon-MM. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module test_bus_arbiter;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic hreq_n = 1'b1;
    logic hsel_n = 1'b1;
    logic d1_n = 1'b1;
    logic d2_n = 1'b1;
    logic [2:0] pnum = 3'h2;
    logic rps = 1'b0;
    logic prio_n = 1'b1;
    logic [3:0] be = 4'hf;
    logic [5:0] peer_n = 6'h3f;
    logic [31:0] rdata, q;
    logic wait_o, g_n, g_oe, rdy, rdy_oe, dg1_n, dg2_n, dg_oe, prio_o, prio_oe, prio_w, g_w, rdy_w;
    logic bus_oe, mclk, mclk_oe;
    logic [5:0] br_o, br_oe, br_w;
    int errors = 0;
    int samples_checked = 0;
    int c1, c2;
    initial begin
        forever #12.5 clk = ~clk;
    end
    bus_arbiter u_bus_arbiter (
        .clk_sys_i(clk), .resetn_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .host_bus_request_n_i(hreq_n), .host_select_n_i(hsel_n), .host_bus_grant_n_i(g_w),
        .host_bus_grant_n_o(g_n), .host_bus_grant_oe_o(g_oe), .host_wait_ready_o(rdy),
        .host_wait_ready_oe_o(rdy_oe), .ext_dma_request_one_n_i(d1_n), .ext_dma_request_two_n_i(d2_n),
        .ext_dma_grant_one_n_o(dg1_n), .ext_dma_grant_two_n_o(dg2_n), .ext_dma_grant_oe_o(dg_oe),
        .processor_number_pins_i(pnum), .peer_bus_request_lines_n_i(br_w), .peer_bus_request_lines_n_o(br_o),
        .peer_bus_request_lines_oe_o(br_oe), .rotating_priority_select_i(rps), .priority_access_n_i(prio_w),
        .priority_access_n_o(prio_o), .priority_access_oe_o(prio_oe), .ext_bus_oe_o(bus_oe),
        .bus_master_clock_out_o(mclk), .bus_master_clock_oe_o(mclk_oe)
    );
    peer_bus_model u_peer_bus_model (
        .peer_req_n_i(peer_n), .prio_req_n_i(prio_n), .own_req_n_i(br_o), .own_req_oe_i(br_oe), .prio_n_i(prio_o),
        .prio_oe_i(prio_oe), .grant_n_i(g_n), .grant_oe_i(g_oe), .ready_i(rdy), .ready_oe_i(rdy_oe),
        .req_lines_n_o(br_w), .prio_line_n_o(prio_w), .grant_line_n_o(g_w), .ready_line_o(rdy_w)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // The request is held until waitrequest is seen low at a rising edge.
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_o !== 1'b0) begin
            k++;
            if (k > 20) begin
                errors++;
                report_and_stop();
            end
            @(posedge clk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_master(input logic v);
        int k;
        k = 0;
        while (g_oe !== v && k < 40) begin
            @(posedge clk);
            k++;
        end
        `CHK("master", v, g_oe)
        if (g_oe !== v) begin
            report_and_stop();
        end
    endtask
    task automatic pulses;
        c1 = 0;
        c2 = 0;
        repeat (8) begin
            @(posedge clk);
            c1 += (dg1_n === 1'b0);
            c2 += (dg2_n === 1'b0);
        end
    endtask
    initial begin
        tick(4);
        `CHK("reset oe", 17'h0, {g_oe, dg_oe, bus_oe, mclk_oe, rdy_oe, prio_oe, br_oe, 5'h0})
        `CHK("reset wait", 1'b1, wait_o)
        rst_n <= 1'b1;
        tick(1);
        av(1'b0, 4'h4, 32'h0);
        `CHK("number", 3'h2, q[5:3])
        av(1'b0, 4'h8, 32'h0);
        `CHK("unmapped", 32'h0, q)
        // Peer two holds, then hands over while we and peer three both request.
        for (int r = 1; r >= 0; r--) begin
            rps <= r[0];
            av(1'b1, 4'h0, 32'h0);
            peer_n <= 6'h3b;
            tick(6);
            av(1'b1, 4'h0, 32'h1);
            peer_n <= 6'h33;
            tick(4);
            `CHK("own line", 6'h02, br_oe)
            `CHK("parked", 1'b0, g_oe)
            peer_n <= 6'h37;
            if (r == 1) begin
                tick(10);
                `CHK("rotate", 1'b0, g_oe)
            end else begin
                wait_master(1'b1);
            end
        end
        peer_n <= 6'h3f;
        tick(2);
        `CHK("bus oe on", 1'b1, bus_oe)
        `CHK("clk oe on", 1'b1, mclk_oe)
        q[0] = mclk;
        tick(1);
        `CHK("clock", ~q[0], mclk)
        hreq_n <= 1'b0;
        peer_n <= 6'h3e;
        tick(2);
        `CHK("bus oe off", 1'b0, bus_oe)
        `CHK("grant early", 1'b1, g_n)
        tick(1);
        `CHK("grant", 1'b0, g_n)
        `CHK("clk oe off", 1'b0, mclk_oe)
        hsel_n <= 1'b0;
        tick(2);
        `CHK("ready", 1'b0, rdy_w)
        av(1'b1, 4'h0, 32'h0);
        tick(3);
        `CHK("grant held", 1'b0, g_n)
        `CHK("frozen", 1'b1, g_oe)
        hsel_n <= 1'b1;
        hreq_n <= 1'b1;
        tick(2);
        `CHK("grant off", 1'b1, g_n)
        `CHK("ready off", 1'b1, rdy_w)
        wait_master(1'b0);
        // As a slave that wants the bus, ask for priority access on the shared line.
        av(1'b1, 4'h0, 32'h11);
        tick(2);
        `CHK("prio drive", 2'b10, {prio_oe, prio_w})
        av(1'b1, 4'h0, 32'hf);
        be <= 4'h0;
        av(1'b1, 4'h0, 32'h0);
        be <= 4'hf;
        av(1'b0, 4'h0, 32'h0);
        `CHK("ctrl kept", 32'hf, q)
        peer_n <= 6'h3f;
        wait_master(1'b1);
        d1_n <= 1'b0;
        pulses();
        `CHK("dma one", 1, c1)
        d1_n <= 1'b1;
        d2_n <= 1'b0;
        pulses();
        `CHK("dma two", 32'h10, c2 * 16 + c1)
        d2_n <= 1'b1;
        tick(1);
        d1_n <= 1'b0;
        d2_n <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (dg1_n === 1'b0 || dg2_n === 1'b0) break;
        end
        `CHK("dma order", 2'b01, {dg1_n, dg2_n})
        d1_n <= 1'b1;
        d2_n <= 1'b1;
        prio_n <= 1'b0;
        tick(2);
        d1_n <= 1'b0;
        pulses();
        `CHK("pa block", 0, c1)
        av(1'b0, 4'h4, 32'h0);
        `CHK("suspended", 1'b1, q[2])
        prio_n <= 1'b1;
        d1_n <= 1'b1;
        // A lone processor has no request line and must still own the bus.
        pnum <= 3'h0;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        av(1'b1, 4'h0, 32'h1);
        wait_master(1'b1);
        `CHK("no line", 6'h00, br_oe)
        report_and_stop();
    end
endmodule
